// ==== src/pfr_pkg.sv ====
/*
  Constants for the pin function and reset control block: register map,
  field positions, pin indices, reset values and timing counts.
  Assumes a single bus clock of 25 MHz and a 32-bit APB master.
*/
// Function
// - Any reset source drives the reset pin low for 66 bus cycles.
// - Decode the reset cause and set its flag in reset_cause_status.
// - Reset pin is open-drain with pull-up; external low forces reset.
// - Debug pin selects mode during POR or forced reset, then serves debug.
// - Debug pin high at internal reset release selects normal run mode.
// - One debug bit time lasts 16 debug clock cycles.
// - Debug pin is pseudo open-drain with brief actively driven high pulses.
// - Up to 22 general-purpose pins, shared with peripheral functions.
// - Output pins offer two drive strengths and optional slew limiting.
// - Input pins offer a software-enabled pull-up.
// - After reset all port pins are high-impedance inputs, pull-ups off.
// - Peripheral owns output enable; direction bits still steer data reads.
// - Ganged output overrides every digital peripheral on that pin.
// - Ganged pins copy output value, drive and slew of port_c_bit0.
// - Two-wire serial pins relocate by i2c_pin_select; default port_a_bit2/3.
// - Timer1 channel pins relocate by select bits; default port_a_bit0, port_b_bit5.
// - Timer2 channel pins relocate by select bits; default port_a_bit1, port_b_bit4.
// - Comparator and converter both receive a shared pin's input.
// - After reset the internal clock source is selected, not the crystal.
// - Bus clock runs at half the internal clock source primary output.
package pfr_pkg;

  // Pin vector: bits 7:0 port A, 15:8 port B, 23:16 port C
  localparam int          PIN_W      = 24;
  localparam int          PIN_COUNT  = 22;
  localparam logic [23:0] PIN_MASK   = 24'hff_ffcf;
  localparam logic [23:0] GANG_MASK  = 24'h0f_3c00;

  localparam int PORT_A_BIT0 = 0;
  localparam int PORT_A_BIT1 = 1;
  localparam int PORT_A_BIT2 = 2;
  localparam int PORT_A_BIT3 = 3;
  localparam int PTA6 = 6;
  localparam int PTA7 = 7;
  localparam int PORT_B_BIT4 = 12;
  localparam int PORT_B_BIT5 = 13;
  localparam int PTB6 = 14;
  localparam int PTB7 = 15;
  localparam int PORT_C_BIT0 = 16;
  localparam int PTC1 = 17;

  // APB byte offsets
  localparam logic [7:0] OFS_CAUSE  = 8'h00;
  localparam logic [7:0] OFS_DBGRST = 8'h04;
  localparam logic [7:0] OFS_SYSTEM_OPTIONS_2  = 8'h08;
  localparam logic [7:0] OFS_MODE   = 8'h0c;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_DIR    = 8'h14;
  localparam logic [7:0] OFS_PULL   = 8'h18;
  localparam logic [7:0] OFS_DRIVE  = 8'h1c;
  localparam logic [7:0] OFS_SLEW   = 8'h20;
  localparam logic [7:0] OFS_GANG   = 8'h24;

  // reset_cause_status bits
  localparam int CAUSE_W   = 6;
  localparam int CS_POR    = 0;
  localparam int CS_PIN    = 1;
  localparam int CS_COP    = 2;
  localparam int CS_ILOP   = 3;
  localparam int CS_LVD    = 4;
  localparam int CS_DBGRST = 5;
  localparam logic [5:0] CAUSE_RESET = 6'h01;

  // system_options_2 bits
  localparam int SYSTEM_OPTIONS_2_W   = 5;
  localparam int SO_T1CH0  = 0;
  localparam int SO_T1CH1  = 1;
  localparam int SO_T2CH0  = 2;
  localparam int SO_T2CH1  = 3;
  localparam int SO_I2C    = 4;

  // Mode register fields
  localparam int MD_DEBUG   = 0;
  localparam int MD_EXTCLK  = 1;
  localparam int MD_DIV_LSB = 4;

  localparam logic [6:0] RESET_HOLD_CYCLES  = 7'd66;
  localparam logic [2:0] RESET_BLANK_CYCLES = 3'd4;
  localparam logic [4:0] BDC_BIT_CYCLES     = 5'd16;
  localparam logic [3:0] BUS_CLK_DIV        = 4'd2;

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_BLANK} pfr_rst_state_t;

endpackage : pfr_pkg

// ==== src/pfr_pin_ctrl.sv ====
/*
  Pin function multiplexer and reset pin control with APB register access.
  Assumes peripherals and the debug engine run on the same bus clock; pad
  inputs are asynchronous and are synchronised here. rst_b is power-on reset.
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pfr_pin_ctrl (
  // Clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Internal reset sources, one-cycle pulses
  input  wire logic        copRstReq,
  input  wire logic        illOpRstReq,
  input  wire logic        lvdRstReq,
  // Reset pin, open drain
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  output logic             resetPinPullup,
  output logic             sysRst_b,
  // Debug mode pin and debug controller side
  input  wire logic        debugPinIn,
  output logic             debugPinOut,
  output logic             debugPinOe,
  input  wire logic        bdcDriveOut,
  input  wire logic        bdcDriveOe,
  output logic             bdcPinIn,
  output logic             bdcBitTick,
  output logic             debugMode,
  output logic             clkSrcExternal,
  // Port pads
  input  wire logic [23:0] padIn,
  output logic [23:0]      padOut,
  output logic [23:0]      padOe,
  output logic [23:0]      padPull,
  output logic [23:0]      padDrive,
  output logic [23:0]      padSlew,
  // Generic digital peripheral claims per pin
  input  wire logic [23:0] perOwn,
  input  wire logic [23:0] perOut,
  input  wire logic [23:0] perOe,
  // Relocatable serial and timer functions
  input  wire logic        i2cEn,
  input  wire logic        i2cSclOut,
  input  wire logic        i2cSclOe,
  input  wire logic        i2cSdaOut,
  input  wire logic        i2cSdaOe,
  output logic             i2cSclIn,
  output logic             i2cSdaIn,
  input  wire logic [1:0]  tpm1En,
  input  wire logic [1:0]  tpm1Out,
  input  wire logic [1:0]  tpm1Oe,
  output logic [1:0]       tpm1In,
  input  wire logic [1:0]  tpm2En,
  input  wire logic [1:0]  tpm2Out,
  input  wire logic [1:0]  tpm2Oe,
  output logic [1:0]       tpm2In,
  // Analog claims and sampled levels
  input  wire logic [23:0] adcChanEn,
  input  wire logic [23:0] acmpPinEn,
  output logic [23:0]      adcPinIn,
  output logic [23:0]      acmpPinIn
);

  pfr_pkg::pfr_rst_state_t rstState_ff, nxt_rstState;
  logic [6:0]  holdCnt_ff;
  logic [2:0]  blankCnt_ff;
  logic [5:0]  causeFlags_ff, nxt_causeFlags;
  logic        modeArm_ff;
  logic        rstMeta_ff, rstSync_ff, dbgMeta_ff, dbgSync_ff;
  logic [23:0] padMeta_ff, padSync_ff;
  logic [4:0]  sopt_ff;
  logic [23:0] dataReg_ff, dirReg_ff, pullReg_ff, driveReg_ff, slewReg_ff, gangReg_ff;
  logic        dbgRstReq_ff, extClkSel_ff;
  logic [3:0]  bdcCnt_ff;
  logic [23:0] muxOut, muxOe, muxDrive, muxSlew, anaEn;
  logic [31:0] rdata;
  logic        softReset, anySrc, mapped, apbWrite;
  logic [6:0]  oeLen_ff;
  int          t1c0Pin, t1c1Pin, t2c0Pin, t2c1Pin, sclPin, sdaPin;

  // Pad synchronisers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= 1'b1;
      dbgMeta_ff <= 1'b1;
      dbgSync_ff <= 1'b1;
      padMeta_ff <= '0;
      padSync_ff <= '0;
    end else begin
      rstMeta_ff <= resetPinIn;
      rstSync_ff <= rstMeta_ff;
      dbgMeta_ff <= debugPinIn;
      dbgSync_ff <= dbgMeta_ff;
      padMeta_ff <= padIn;
      padSync_ff <= padMeta_ff;
    end
  end

  // Reset sequencer
  assign softReset = (rstState_ff != pfr_pkg::ST_RUN);
  assign anySrc    = copRstReq | illOpRstReq | lvdRstReq | dbgRstReq_ff | ~rstSync_ff;

  always_comb begin
    nxt_rstState   = rstState_ff;
    nxt_causeFlags = causeFlags_ff;
    case (rstState_ff)
      pfr_pkg::ST_RUN: begin
        if (anySrc) begin
          nxt_rstState                      = pfr_pkg::ST_HOLD;
          nxt_causeFlags                    = '0;
          nxt_causeFlags[pfr_pkg::CS_PIN]   = ~rstSync_ff;
          nxt_causeFlags[pfr_pkg::CS_COP]   = copRstReq;
          nxt_causeFlags[pfr_pkg::CS_ILOP]  = illOpRstReq;
          nxt_causeFlags[pfr_pkg::CS_LVD]   = lvdRstReq;
          nxt_causeFlags[pfr_pkg::CS_DBGRST] = dbgRstReq_ff;
        end
      end
      pfr_pkg::ST_HOLD: begin
        if (holdCnt_ff == 7'd0) begin
          nxt_rstState = pfr_pkg::ST_BLANK;
        end
      end
      pfr_pkg::ST_BLANK: begin
        // Pin rises slowly through the pull-up; a held switch stretches reset
        if (blankCnt_ff == 3'd0 && rstSync_ff) begin
          nxt_rstState = pfr_pkg::ST_RUN;
        end
      end
      default: nxt_rstState = pfr_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstState_ff    <= pfr_pkg::ST_HOLD;
      holdCnt_ff     <= pfr_pkg::RESET_HOLD_CYCLES - 7'd1;
      blankCnt_ff    <= pfr_pkg::RESET_BLANK_CYCLES;
      causeFlags_ff  <= pfr_pkg::CAUSE_RESET;
      resetPinOe     <= 1'b1;
      sysRst_b       <= 1'b0;
    end else begin
      rstState_ff   <= nxt_rstState;
      causeFlags_ff <= nxt_causeFlags;
      resetPinOe    <= (nxt_rstState == pfr_pkg::ST_HOLD);
      sysRst_b      <= (nxt_rstState == pfr_pkg::ST_RUN);
      if (rstState_ff == pfr_pkg::ST_RUN) begin
        holdCnt_ff <= pfr_pkg::RESET_HOLD_CYCLES - 7'd1;
      end else if (holdCnt_ff != 7'd0) begin
        holdCnt_ff <= holdCnt_ff - 7'd1;
      end
      if (rstState_ff != pfr_pkg::ST_BLANK) begin
        blankCnt_ff <= pfr_pkg::RESET_BLANK_CYCLES;
      end else if (blankCnt_ff != 3'd0) begin
        blankCnt_ff <= blankCnt_ff - 3'd1;
      end
    end
  end

  // Mode select: only power-on and debug-forced resets sample the debug pin
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      modeArm_ff <= 1'b1;
      debugMode  <= 1'b0;
    end else begin
      if (rstState_ff == pfr_pkg::ST_RUN && dbgRstReq_ff) begin
        modeArm_ff <= 1'b1;
      end else if (rstState_ff == pfr_pkg::ST_BLANK && nxt_rstState == pfr_pkg::ST_RUN) begin
        modeArm_ff <= 1'b0;
        debugMode  <= modeArm_ff & ~dbgSync_ff;
      end
    end
  end

  // Debug pin: input only while in reset, debug engine drives it afterwards
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      debugPinOut    <= 1'b0;
      debugPinOe     <= 1'b0;
      bdcPinIn       <= 1'b1;
      bdcCnt_ff      <= '0;
      bdcBitTick     <= 1'b0;
      resetPinOut    <= 1'b0;
      resetPinPullup <= 1'b1;
    end else begin
      debugPinOut    <= bdcDriveOut;
      debugPinOe     <= bdcDriveOe & (nxt_rstState == pfr_pkg::ST_RUN);
      bdcPinIn       <= dbgSync_ff;
      bdcCnt_ff      <= bdcCnt_ff + 4'd1;
      bdcBitTick     <= ({1'b0, bdcCnt_ff} == pfr_pkg::BDC_BIT_CYCLES - 5'd1);
      resetPinOut    <= 1'b0;
      resetPinPullup <= 1'b1;
    end
  end

  // Pin relocation targets
  assign t1c0Pin = sopt_ff[pfr_pkg::SO_T1CH0] ? pfr_pkg::PORT_C_BIT0 : pfr_pkg::PORT_A_BIT0;
  assign t1c1Pin = sopt_ff[pfr_pkg::SO_T1CH1] ? pfr_pkg::PTC1 : pfr_pkg::PORT_B_BIT5;
  assign t2c0Pin = sopt_ff[pfr_pkg::SO_T2CH0] ? pfr_pkg::PTA6 : pfr_pkg::PORT_A_BIT1;
  assign t2c1Pin = sopt_ff[pfr_pkg::SO_T2CH1] ? pfr_pkg::PTA7 : pfr_pkg::PORT_B_BIT4;
  assign sdaPin  = sopt_ff[pfr_pkg::SO_I2C] ? pfr_pkg::PTB6 : pfr_pkg::PORT_A_BIT2;
  assign sclPin  = sopt_ff[pfr_pkg::SO_I2C] ? pfr_pkg::PTB7 : pfr_pkg::PORT_A_BIT3;
  assign anaEn   = adcChanEn | acmpPinEn;

  // Pin multiplexer: each later stage outranks the one before
  always_comb begin
    muxOut   = dataReg_ff;
    muxOe    = dirReg_ff;
    muxDrive = driveReg_ff;
    muxSlew  = slewReg_ff;
    for (int i = 0; i < pfr_pkg::PIN_W; i++) begin
      if (perOwn[i]) begin
        muxOut[i] = perOut[i];
        muxOe[i]  = perOe[i];
      end
    end
    if (tpm1En[0]) begin
      muxOut[t1c0Pin] = tpm1Out[0];
      muxOe[t1c0Pin]  = tpm1Oe[0];
    end
    if (tpm1En[1]) begin
      muxOut[t1c1Pin] = tpm1Out[1];
      muxOe[t1c1Pin]  = tpm1Oe[1];
    end
    if (tpm2En[0]) begin
      muxOut[t2c0Pin] = tpm2Out[0];
      muxOe[t2c0Pin]  = tpm2Oe[0];
    end
    if (tpm2En[1]) begin
      muxOut[t2c1Pin] = tpm2Out[1];
      muxOe[t2c1Pin]  = tpm2Oe[1];
    end
    if (i2cEn) begin
      muxOut[sdaPin] = i2cSdaOut;
      muxOe[sdaPin]  = i2cSdaOe;
      muxOut[sclPin] = i2cSclOut;
      muxOe[sclPin]  = i2cSclOe;
    end
    for (int i = 0; i < pfr_pkg::PIN_W; i++) begin
      if (gangReg_ff[i] && pfr_pkg::GANG_MASK[i]) begin
        muxOut[i]   = dataReg_ff[pfr_pkg::PORT_C_BIT0];
        muxOe[i]    = 1'b1;
        muxDrive[i] = driveReg_ff[pfr_pkg::PORT_C_BIT0];
        muxSlew[i]  = slewReg_ff[pfr_pkg::PORT_C_BIT0];
      end
      if (anaEn[i] || softReset) begin
        muxOe[i] = 1'b0;
      end
    end
    muxOe = muxOe & pfr_pkg::PIN_MASK;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      padOut    <= '0;
      padOe     <= '0;
      padPull   <= '0;
      padDrive  <= '0;
      padSlew   <= '0;
      adcPinIn  <= '0;
      acmpPinIn <= '0;
      i2cSclIn  <= 1'b1;
      i2cSdaIn  <= 1'b1;
      tpm1In    <= '0;
      tpm2In    <= '0;
    end else begin
      padOut    <= muxOut & muxOe;
      padOe     <= muxOe;
      padPull   <= pullReg_ff & ~muxOe & pfr_pkg::PIN_MASK & {24{~softReset}};
      padDrive  <= muxDrive & muxOe;
      padSlew   <= muxSlew & muxOe;
      adcPinIn  <= padSync_ff & adcChanEn;
      acmpPinIn <= padSync_ff & acmpPinEn;
      i2cSclIn  <= padSync_ff[sclPin];
      i2cSdaIn  <= padSync_ff[sdaPin];
      tpm1In    <= {padSync_ff[t1c1Pin], padSync_ff[t1c0Pin]};
      tpm2In    <= {padSync_ff[t2c1Pin], padSync_ff[t2c0Pin]};
    end
  end

  // APB slave: one wait state, access completes in the second penable cycle
  assign apbWrite = psel & penable & pready & pwrite;
  always_comb begin
    rdata  = '0;
    mapped = 1'b1;
    case (paddr)
      pfr_pkg::OFS_CAUSE:  rdata[5:0]  = causeFlags_ff;
      pfr_pkg::OFS_DBGRST: rdata       = '0;
      pfr_pkg::OFS_SYSTEM_OPTIONS_2:  rdata[4:0]  = sopt_ff;
      pfr_pkg::OFS_MODE: begin
        rdata[pfr_pkg::MD_DEBUG]                         = debugMode;
        rdata[pfr_pkg::MD_EXTCLK]                        = extClkSel_ff;
        rdata[pfr_pkg::MD_DIV_LSB +: 4]                  = pfr_pkg::BUS_CLK_DIV;
      end
      // Direction picks latch or pad even when a peripheral owns the pin
      pfr_pkg::OFS_DATA:   rdata[23:0] = (dataReg_ff & dirReg_ff) | (padSync_ff & ~dirReg_ff & pfr_pkg::PIN_MASK);
      pfr_pkg::OFS_DIR:    rdata[23:0] = dirReg_ff;
      pfr_pkg::OFS_PULL:   rdata[23:0] = pullReg_ff;
      pfr_pkg::OFS_DRIVE:  rdata[23:0] = driveReg_ff;
      pfr_pkg::OFS_SLEW:   rdata[23:0] = slewReg_ff;
      pfr_pkg::OFS_GANG:   rdata[23:0] = gangReg_ff;
      default:             mapped      = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata : '0;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // Software registers; every reset returns them to their defaults
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sopt_ff      <= '0;
      dataReg_ff   <= '0;
      dirReg_ff    <= '0;
      pullReg_ff   <= '0;
      driveReg_ff  <= '0;
      slewReg_ff   <= '0;
      gangReg_ff   <= '0;
      dbgRstReq_ff <= 1'b0;
      extClkSel_ff <= 1'b0;
    end else if (softReset) begin
      sopt_ff      <= '0;
      dataReg_ff   <= '0;
      dirReg_ff    <= '0;
      pullReg_ff   <= '0;
      driveReg_ff  <= '0;
      slewReg_ff   <= '0;
      gangReg_ff   <= '0;
      dbgRstReq_ff <= 1'b0;
      extClkSel_ff <= 1'b0;
    end else begin
      dbgRstReq_ff <= apbWrite && paddr == pfr_pkg::OFS_DBGRST && pwdata[0];
      if (apbWrite) begin
        case (paddr)
          pfr_pkg::OFS_SYSTEM_OPTIONS_2: sopt_ff      <= pwdata[4:0];
          pfr_pkg::OFS_MODE:  extClkSel_ff <= pwdata[pfr_pkg::MD_EXTCLK];
          pfr_pkg::OFS_DATA:  dataReg_ff   <= pwdata[23:0] & pfr_pkg::PIN_MASK;
          pfr_pkg::OFS_DIR:   dirReg_ff    <= pwdata[23:0] & pfr_pkg::PIN_MASK;
          pfr_pkg::OFS_PULL:  pullReg_ff   <= pwdata[23:0] & pfr_pkg::PIN_MASK;
          pfr_pkg::OFS_DRIVE: driveReg_ff  <= pwdata[23:0] & pfr_pkg::PIN_MASK;
          pfr_pkg::OFS_SLEW:  slewReg_ff   <= pwdata[23:0] & pfr_pkg::PIN_MASK;
          pfr_pkg::OFS_GANG:  gangReg_ff   <= pwdata[23:0] & pfr_pkg::GANG_MASK;
          default:            ;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clkSrcExternal <= 1'b0;
      oeLen_ff       <= '0;
    end else begin
      clkSrcExternal <= extClkSel_ff & ~softReset;
      oeLen_ff       <= resetPinOe ? oeLen_ff + 7'd1 : 7'd0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_reset_hold_len: assert property ($fell(resetPinOe) |-> oeLen_ff == pfr_pkg::RESET_HOLD_CYCLES)
    else $error("reset pin not held low for the hold count");
  chk_cause_cop: assert property (rstState_ff == pfr_pkg::ST_RUN && copRstReq |=> causeFlags_ff[pfr_pkg::CS_COP] ##1 resetPinOe)
    else $error("watchdog reset not recorded");
  chk_pin_forces_reset: assert property (rstState_ff == pfr_pkg::ST_RUN && !rstSync_ff |=> resetPinOe && !sysRst_b)
    else $error("external reset pin low ignored");
  chk_debug_pin_quiet: assert property (!sysRst_b |-> !debugPinOe)
    else $error("debug pin driven during reset");
  chk_mode_select: assert property ($rose(sysRst_b) |-> debugMode == ($past(modeArm_ff) && !$past(dbgSync_ff)))
    else $error("wrong startup mode");
  chk_bit_time: assert property (bdcBitTick |=> !bdcBitTick ##15 bdcBitTick)
    else $error("debug bit tick spacing wrong");
  chk_reset_gpio: assert property (!sysRst_b |=> padOe == '0 && padPull == '0)
    else $error("port pin not released in reset");
  chk_gang_override: assert property (sysRst_b && gangReg_ff[pfr_pkg::PORT_B_BIT4] && !anaEn[pfr_pkg::PORT_B_BIT4] |=>
    padOe[pfr_pkg::PORT_B_BIT4] && padOut[pfr_pkg::PORT_B_BIT4] == $past(dataReg_ff[pfr_pkg::PORT_C_BIT0]))
    else $error("ganged pin not overriding");
  chk_gang_copy: assert property (sysRst_b && gangReg_ff[pfr_pkg::PORT_B_BIT4] && !anaEn[pfr_pkg::PORT_B_BIT4] |=>
    padDrive[pfr_pkg::PORT_B_BIT4] == $past(driveReg_ff[pfr_pkg::PORT_C_BIT0]))
    else $error("ganged pin drive not copied");
  chk_i2c_default: assert property (sysRst_b && i2cEn && !sopt_ff[pfr_pkg::SO_I2C] && !anaEn[pfr_pkg::PORT_A_BIT3] |=>
    padOe[pfr_pkg::PORT_A_BIT3] == $past(i2cSclOe))
    else $error("serial clock not on default pin");
  chk_analog_share: assert property (adcChanEn[pfr_pkg::PORT_A_BIT0] && acmpPinEn[pfr_pkg::PORT_A_BIT0] |=>
    adcPinIn[pfr_pkg::PORT_A_BIT0] == acmpPinIn[pfr_pkg::PORT_A_BIT0])
    else $error("analog users see different levels");
  chk_clk_internal: assert property (!sysRst_b |=> !clkSrcExternal)
    else $error("external clock kept through reset");

  cov_debug_start: cover property ($rose(sysRst_b) && debugMode);
  cov_pin_reset: cover property ($rose(causeFlags_ff[pfr_pkg::CS_PIN]));
  cov_forced_reset: cover property ($rose(causeFlags_ff[pfr_pkg::CS_DBGRST]));

endmodule : pfr_pin_ctrl
`default_nettype wire

// ==== sim/pfr_board.sv ====
/*
  Board model: reset pad with pull-up and a switch to ground, debug pad with
  pull-up and a host that may hold it low. Assumes pure levels, no delays.
*/
`timescale 1ns/1ns
`default_nettype none
module pfr_board (
  // Reset pad
  input  wire logic resetPinOe,
  input  wire logic extLow,
  output logic      resetPinIn,
  // Debug pad
  input  wire logic debugPinOut,
  input  wire logic debugPinOe,
  input  wire logic hostLow,
  output logic      debugPinIn
);
  // Open drain: device or switch pulls low, pull-up otherwise
  assign resetPinIn = (resetPinOe || extLow) ? 1'b0 : 1'b1;
  // Host holding low wins, so a device high pulse never masks it
  assign debugPinIn = hostLow ? 1'b0 : (debugPinOe ? debugPinOut : 1'b1);
endmodule : pfr_board
`default_nettype wire

// ==== sim/pin_function_and_reset_control_tb.sv ====
/*
  Self-checking bench for the pin and reset control block.
  Assumes the board model pfr_board and one 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_function_and_reset_control_tb;
  logic        clock = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        extLow = 1'h0, hostLow = 1'h0, fnOn = 1'h0, bdcOn = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, d, p, e;
  logic        pready, pslverr, resetPinIn, resetPinOe, resetPinPullup, sysRst_b;
  logic        debugPinIn, debugPinOut, debugPinOe, bdcBitTick, clkSrcExternal, bdcPinIn, resetPinOut;
  logic [2:0]  src = 3'h0;
  logic [23:0] padIn = 24'h0, perOwn = 24'h0, perOut = 24'h0, perOe = 24'h0, adcChanEn = 24'h0, acmpPinEn = 24'h0;
  logic [23:0] padOut, padOe, padPull, padDrive, padSlew, adcPinIn, acmpPinIn;
  logic [31:0] expQ[$];
  int          numErrors = 0, numChecks = 0, n;

  always #20 clock = ~clock;

  pfr_pin_ctrl dut_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .copRstReq(src[0]), .illOpRstReq(src[1]), .lvdRstReq(src[2]), .resetPinIn, .resetPinOut, .resetPinOe,
    .resetPinPullup, .sysRst_b, .debugPinIn, .debugPinOut, .debugPinOe, .bdcDriveOut(bdcOn), .bdcDriveOe(bdcOn),
    .bdcPinIn, .bdcBitTick, .debugMode(), .clkSrcExternal, .padIn, .padOut, .padOe, .padPull, .padDrive,
    .padSlew, .perOwn, .perOut, .perOe, .i2cEn(fnOn), .i2cSclOut(fnOn), .i2cSclOe(fnOn), .i2cSdaOut(fnOn),
    .i2cSdaOe(fnOn), .i2cSclIn(), .i2cSdaIn(), .tpm1En({2{fnOn}}), .tpm1Out({2{fnOn}}), .tpm1Oe({2{fnOn}}),
    .tpm1In(), .tpm2En({2{fnOn}}), .tpm2Out({2{fnOn}}), .tpm2Oe({2{fnOn}}), .tpm2In(), .adcChanEn, .acmpPinEn,
    .adcPinIn, .acmpPinIn);
  pfr_board board_u (.resetPinOe, .extLow, .resetPinIn, .debugPinOut, .debugPinOe, .hostLow, .debugPinIn);

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    numChecks++;
    if (got !== ex) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic close_out;
    if (numErrors == 0 && numChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Idle edge first, so psel is never assigned twice in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge clock) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) numErrors++;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    expQ.push_back(ex);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle;
    repeat (4) @(posedge clock);
  endtask : settle

  // Counts pull edges over a fixed window, then waits for release
  task automatic rstRun(output int cnt);
    int k;
    cnt = 0;
    repeat (100) begin
      @(posedge clock);
      if (resetPinOe === 1'b1) cnt++;
    end
    k = 0;
    while (sysRst_b !== 1'b1 && k < 50) begin
      @(posedge clock);
      k++;
    end
    if (k >= 50) numErrors++;
  endtask : rstRun

  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", expQ.pop_front(), prdata);
      chk("pslverr", 32'(paddr > pfr_pkg::OFS_GANG), pslverr);
    end
  end

  initial begin
    #400000;
    numErrors++;
    close_out();
  end

  initial begin
    r = $urandom(32'hc3e841d1);
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rstRun(n);
    apb(1'b1, pfr_pkg::OFS_CAUSE, 32'h3f);
    rd(pfr_pkg::OFS_CAUSE, 32'h01);
    rd(pfr_pkg::OFS_MODE, 32'h20);
    rd(8'h3c, 32'h0);
    chk("padOe", 32'h0, padOe);
    chk("padPull", 32'h0, padPull);
    chk("clkSrc", 32'h0, clkSrcExternal);
    chk("pullup", 32'h1, resetPinPullup);
    chk("rstOut", 32'h0, resetPinOut);
    n = -99;
    repeat (40) begin
      @(posedge clock);
      n++;
      if (bdcBitTick === 1'b1) begin
        if (n > 0) chk("tickGap", 32'd16, n);
        n = 0;
      end
    end
    for (int i = 0; i < 3; i++) begin
      src <= 3'h1 << i;
      @(posedge clock) src <= 3'h0;
      rstRun(n);
      chk("holdCycles", 32'd66, n);
      rd(pfr_pkg::OFS_CAUSE, 32'h4 << i);
    end
    extLow <= 1'b1;
    repeat (5) @(posedge clock);
    extLow <= 1'b0;
    rstRun(n);
    rd(pfr_pkg::OFS_CAUSE, 32'h02);
    hostLow <= 1'b1;
    apb(1'b1, pfr_pkg::OFS_DBGRST, 32'h1);
    rstRun(n);
    hostLow <= 1'b0;
    rd(pfr_pkg::OFS_MODE, 32'h21);
    rd(pfr_pkg::OFS_CAUSE, 32'h20);
    bdcOn <= 1'b1;
    settle();
    chk("dbgOe", 32'h1, debugPinOe);
    chk("dbgPin", 32'h1, debugPinIn);
    chk("bdcIn", 32'h1, bdcPinIn);
    bdcOn <= 1'b0;
    fnOn <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, pfr_pkg::OFS_SYSTEM_OPTIONS_2, s ? 32'h1f : 32'h0);
      settle();
      chk("padOe", s ? 32'h03c0c0 : 32'h00300f, padOe);
    end
    fnOn <= 1'b0;
    padIn <= 24'h1;
    adcChanEn <= 24'h1;
    acmpPinEn <= 24'h1;
    settle();
    chk("adcIn", 32'h1, adcPinIn);
    chk("acmpIn", 32'h1, acmpPinIn);
    adcChanEn <= 24'h0;
    acmpPinEn <= 24'h0;
    r = $urandom & pfr_pkg::PIN_MASK;
    d = $urandom & pfr_pkg::PIN_MASK;
    p = $urandom & pfr_pkg::PIN_MASK;
    padIn <= p[23:0];
    apb(1'b1, pfr_pkg::OFS_DIR, r);
    apb(1'b1, pfr_pkg::OFS_DATA, d);
    apb(1'b1, pfr_pkg::OFS_PULL, d);
    apb(1'b1, pfr_pkg::OFS_DRIVE, d);
    apb(1'b1, pfr_pkg::OFS_SLEW, p);
    settle();
    e = (d & r) | (p & ~r);
    chk("padOe", r, padOe);
    chk("padOut", d & r, padOut);
    chk("padPull", d & ~r, padPull);
    chk("padDrive", d & r, padDrive);
    chk("padSlew", p & r, padSlew);
    rd(pfr_pkg::OFS_DATA, e);
    perOwn <= 24'h100;
    perOut <= 24'h100;
    perOe <= 24'h100;
    settle();
    chk("padOe", r | 32'h100, padOe);
    rd(pfr_pkg::OFS_DATA, e);
    perOwn <= pfr_pkg::GANG_MASK;
    perOe <= pfr_pkg::GANG_MASK;
    perOut <= 24'h0;
    apb(1'b1, pfr_pkg::OFS_DIR, 32'h10000);
    apb(1'b1, pfr_pkg::OFS_DATA, 32'h10000);
    apb(1'b1, pfr_pkg::OFS_DRIVE, 32'h10000);
    apb(1'b1, pfr_pkg::OFS_SLEW, 32'h0);
    apb(1'b1, pfr_pkg::OFS_GANG, 32'(pfr_pkg::GANG_MASK));
    settle();
    chk("gangOut", 32'(pfr_pkg::GANG_MASK), padOut);
    chk("gangDrive", 32'(pfr_pkg::GANG_MASK), padDrive);
    chk("gangSlew", 32'h0, padSlew);
    close_out();
  end
endmodule : pin_function_and_reset_control_tb
`default_nettype wire
